// File: hw/cpram_params.svh
/*
 Offsets, field positions, reset values and timing counts for the port RAM
 indirect access block. Assumes inclusion by bare name from hw/.
*/
`ifndef CPRAM_PARAMS_SVH
`define CPRAM_PARAMS_SVH
`define CPRAM_SEL_OFS      8'h00
`define CPRAM_DATA_OFS     8'h04
`define CPRAM_SEL_TS_LO    0
`define CPRAM_SEL_TS_HI    6
`define CPRAM_SEL_BANK_LO  8
`define CPRAM_SEL_BANK_HI  9
`define CPRAM_SEL_DIR      14
`define CPRAM_SEL_BUSY     15
`define CPRAM_CFG_CHAN_HI  7
`define CPRAM_CFG_SEVEN    8
`define CPRAM_CFG_LLOOP    10
`define CPRAM_CFG_SEARCH   12
`define CPRAM_CFG_TESTER   14
`define CPRAM_CFG_ENABLE   15
`define CPRAM_SEL_RESET    16'h0000
`define CPRAM_DATA_RESET   16'h0000
`define CPRAM_SEL_WMASK    16'h437F
`define CPRAM_ACCESS_CYC   2
`endif

// File: hw/cpram_pkg.sv
/*
 Types for the port RAM indirect access block.
 Assumes cpram_params.svh is compiled alongside.
*/
package cpram_pkg;
  typedef enum logic [1:0] {
    CPRAM_BANK_BYTES = 2'b00,
    CPRAM_BANK_RXCFG = 2'b01,
    CPRAM_BANK_TXCFG = 2'b10,
    CPRAM_BANK_BAD   = 2'b11
  } cpram_bank_e;
  typedef enum logic [2:0] {
    CPRAM_IDLE = 3'b001,
    CPRAM_READ = 3'b010,
    CPRAM_WRITE = 3'b100
  } cpram_state_e;
  typedef struct packed {
    logic [7:0] rxByte;
    logic       rxValid;
    logic [7:0] txByte;
    logic       txValid;
    logic [6:0] slot;
  } cpram_line_s;
  typedef struct packed {
    logic [7:0] hdlcByte;
    logic [8:0] hdlcChannel;
    logic       hdlcValid;
    logic       sevenBit;
    logic [7:0] searchByte;
    logic       searchValid;
    logic [7:0] testerByte;
    logic       testerValid;
  } cpram_rxout_s;
endpackage : cpram_pkg

// File: hw/cpram_port.sv
/*
 One port's RAM: byte store, receive and transmit configuration banks,
 reached indirectly through select and data registers on classic Wishbone,
 plus the receive per-timeslot path steered by the receive configuration.
 Assumes the line side delivers one timeslot byte per valid pulse on sys_clk.
*/
`timescale 1ns/10ps
`include "cpram_params.svh"
module cpram_port
  import cpram_pkg::*;
#(
  parameter int SLOTS = 128
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         rxUnchannelized,
  input  wire cpram_line_s  lineIn,
  output cpram_rxout_s      rxOut,
  output logic [15:0]       txCfgWord
);
  localparam int AW = $clog2(SLOTS);

  logic [15:0]   byteMem [SLOTS];
  logic [15:0]   rxCfgMem [SLOTS];
  logic [15:0]   txCfgMem [SLOTS];
  logic [15:0]   selQ;
  logic [15:0]   dataQ;
  logic          ackQ;
  logic [31:0]   rdatQ;
  cpram_state_e  stateQ;
  logic [1:0]    cntQ;
  logic [15:0]   fetchQ;
  logic [15:0]   slotCfg;
  logic [15:0]   cfg0;
  logic [7:0]    loopByte;
  logic [7:0]    rxData;
  logic          active;
  logic          loopOn;
  logic          chanMode;

  wire           busReq   = wb_cyc_i && wb_stb_i && !ackQ;
  wire           selHit   = wb_adr_i == `CPRAM_SEL_OFS;
  wire           dataHit  = wb_adr_i == `CPRAM_DATA_OFS;
  wire           busy     = stateQ != CPRAM_IDLE;
  wire [AW-1:0]  slotAddr = selQ[`CPRAM_SEL_TS_HI:`CPRAM_SEL_TS_LO];
  wire [1:0]     bank     = selQ[`CPRAM_SEL_BANK_HI:`CPRAM_SEL_BANK_LO];
  wire           lowLanes = wb_sel_i[0] && wb_sel_i[1];

  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  sel);
    mergeLanes = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction : mergeLanes

  // Bus slave: one wait state, unmapped reads return zero and writes drop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= busReq;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdatQ <= 32'h0000_0000;
    end else if (busReq) begin
      if (selHit) begin
        rdatQ <= {16'h0000, busy, selQ[14:0]};
      end else if (dataHit) begin
        rdatQ <= {16'h0000, dataQ};
      end else begin
        rdatQ <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdatQ;

  // A select write is only honoured as a whole halfword, so a new access
  // never starts from a half-updated select word
  wire startAcc = busReq && wb_we_i && selHit && lowLanes && !busy;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      selQ <= `CPRAM_SEL_RESET;
    end else if (startAcc) begin
      selQ <= wb_dat_i[15:0] & `CPRAM_SEL_WMASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stateQ <= CPRAM_IDLE;
      cntQ   <= 2'd0;
    end else begin
      unique case (stateQ)
        CPRAM_IDLE: begin
          cntQ <= 2'd0;
          if (startAcc) begin
            stateQ <= wb_dat_i[`CPRAM_SEL_DIR] ? CPRAM_READ : CPRAM_WRITE;
          end
        end
        CPRAM_READ, CPRAM_WRITE: begin
          cntQ <= cntQ + 2'd1;
          if (cntQ == 2'(`CPRAM_ACCESS_CYC - 1)) begin
            stateQ <= CPRAM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    unique case (bank)
      CPRAM_BANK_BYTES: fetchQ <= byteMem[slotAddr];
      CPRAM_BANK_RXCFG: fetchQ <= rxCfgMem[slotAddr];
      CPRAM_BANK_TXCFG: fetchQ <= txCfgMem[slotAddr];
      CPRAM_BANK_BAD:   fetchQ <= 16'h0000;
    endcase
  end

  wire readDone  = stateQ == CPRAM_READ && cntQ == 2'(`CPRAM_ACCESS_CYC - 1);
  wire writeDone = stateQ == CPRAM_WRITE && cntQ == 2'(`CPRAM_ACCESS_CYC - 1);

  // Host writes to the data register while busy are dropped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dataQ <= `CPRAM_DATA_RESET;
    end else if (readDone) begin
      dataQ <= fetchQ;
    end else if (busReq && wb_we_i && dataHit && !busy) begin
      dataQ <= mergeLanes(dataQ, wb_dat_i, wb_sel_i);
    end
  end

  // Line captures win over a host store to the byte bank in the same cycle, whatever slot the host store targets
  always_ff @(posedge sys_clk) begin
    if (writeDone && bank == CPRAM_BANK_RXCFG) begin
      rxCfgMem[slotAddr] <= dataQ;
    end
    if (writeDone && bank == CPRAM_BANK_TXCFG) begin
      txCfgMem[slotAddr] <= dataQ;
    end
  end

  wire hostByteWr = writeDone && bank == CPRAM_BANK_BYTES;
  always_ff @(posedge sys_clk) begin
    if (lineIn.rxValid) begin
      byteMem[lineIn.slot][7:0] <= lineIn.rxByte;
    end else if (hostByteWr) begin
      byteMem[slotAddr][7:0] <= dataQ[7:0];
    end
    if (lineIn.txValid) begin
      byteMem[lineIn.slot][15:8] <= lineIn.txByte;
    end else if (hostByteWr) begin
      byteMem[slotAddr][15:8] <= dataQ[15:8];
    end
  end

  // Receive path
  always_comb begin
    slotCfg  = rxCfgMem[lineIn.slot];
    cfg0     = rxCfgMem[0];
    loopByte = byteMem[lineIn.slot][15:8];
    chanMode = !rxUnchannelized;
    active   = chanMode ? slotCfg[`CPRAM_CFG_ENABLE] : cfg0[`CPRAM_CFG_ENABLE];
    loopOn   = slotCfg[`CPRAM_CFG_LLOOP] && slotCfg[`CPRAM_CFG_ENABLE]
               && !slotCfg[`CPRAM_CFG_SEVEN] && chanMode;
    rxData   = loopOn ? loopByte : lineIn.rxByte;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxOut <= '0;
    end else begin
      rxOut.hdlcValid   <= lineIn.rxValid && active;
      rxOut.hdlcByte    <= rxData;
      rxOut.sevenBit    <= chanMode && slotCfg[`CPRAM_CFG_SEVEN];
      rxOut.hdlcChannel <= 9'(chanMode ? slotCfg[`CPRAM_CFG_CHAN_HI:0]
                                       : cfg0[`CPRAM_CFG_CHAN_HI:0]) + 9'd1;
      rxOut.searchByte  <= lineIn.rxByte;
      rxOut.searchValid <= lineIn.rxValid
                           && (rxUnchannelized || slotCfg[`CPRAM_CFG_SEARCH]);
      rxOut.testerByte  <= rxData;
      rxOut.testerValid <= lineIn.rxValid && slotCfg[`CPRAM_CFG_TESTER];
    end
  end

  // Transmit configuration exposed for the transmit state machine
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txCfgWord <= 16'h0000;
    end else begin
      txCfgWord <= txCfgMem[lineIn.slot];
    end
  end

  busy_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (startAcc && wb_dat_i[14]) |=> busy [*2] ##1 !busy)
    else $error("busy not held for read");
  busy_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (startAcc && !wb_dat_i[14]) |=> busy ##1 busy ##1 !busy)
    else $error("busy not held for write");
  read_data_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    readDone |=> dataQ == $past(fetchQ))
    else $error("read result not in data register");
  busy_ro_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (startAcc && wb_dat_i[15]) |=> !selQ[15] && busy)
    else $error("host write reached busy bit");
  ack_once_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  chan_plus_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lineIn.rxValid && !rxUnchannelized)
      |=> rxOut.hdlcChannel == 9'($past(slotCfg[7:0])) + 9'd1)
    else $error("channel number not offset by one");
  unchan_ch0_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rxUnchannelized |=> rxOut.hdlcChannel == 9'($past(cfg0[7:0])) + 9'd1)
    else $error("unchannelized channel not from entry 0");
  loop_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lineIn.rxValid && slotCfg[8]) |=> rxOut.hdlcByte == $past(lineIn.rxByte))
    else $error("local loop active in seven-bit mode");
  search_raw_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    lineIn.rxValid |=> rxOut.searchByte == $past(lineIn.rxByte))
    else $error("search byte altered");
  search_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lineIn.rxValid && !rxUnchannelized && !slotCfg[12]) |=> !rxOut.searchValid)
    else $error("excluded slot fed to search");
endmodule : cpram_port

// File: dv/cpram_port_tb.sv
/*
 Self-checking bench for cpram_port: classic Wishbone tasks plus line-side pulses.
 Assumes the package and cpram_params.svh from hw/ are compiled first.
*/
`timescale 1ns/10ps
`include "cpram_params.svh"
module cpram_port_tb
  import cpram_pkg::*;
;
  logic         sys_clk, rstn, wbCyc, wbStb, wbWe, rxUnchannelized, wbAck;
  logic [7:0]   wbAdr;
  logic [3:0]   wbSel;
  logic [31:0]  wbDatI, wbDatO, rdv;
  logic [15:0]  txCfgWord;
  cpram_line_s  lineIn;
  cpram_rxout_s rxOut, got;
  int           n_fail, compares;

  cpram_port #(.SLOTS(128)) dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .rxUnchannelized(rxUnchannelized), .lineIn(lineIn), .rxOut(rxOut),
    .txCfgWord(txCfgWord));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until the edge that samples ack; data taken at that edge
  task automatic wbx(input logic we, input logic [7:0] a, input logic [15:0] d);
    int i;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbSel  <= 4'hf;
    wbDatI <= {16'h0000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (wbAck === 1'b1) break;
    end
    rdv = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
    if (i == 20) begin
      n_fail++;
      stop_test();
    end
  endtask : wbx

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
    wbx(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, e}, rdv);
  endtask : rd_chk

  // Busy is polled under a bound; a stuck flag ends the run
  task automatic wait_idle();
    int i;
    for (i = 0; i < 10; i++) begin
      wbx(1'b0, `CPRAM_SEL_OFS, 16'h0000);
      if (rdv[15] === 1'b0) break;
    end
    chk("busy", 32'h0000_0000, {31'h0000_0000, rdv[15]});
    if (i == 10) stop_test();
  endtask : wait_idle

  task automatic put(input logic [1:0] b, input logic [6:0] s, input logic [15:0] v);
    wbx(1'b1, `CPRAM_DATA_OFS, v);
    wbx(1'b1, `CPRAM_SEL_OFS, {6'h00, b, 1'b0, s});
    wait_idle();
  endtask : put

  task automatic get(input string nm, input logic [1:0] b, input logic [6:0] s,
                     input logic [15:0] e);
    wbx(1'b1, `CPRAM_SEL_OFS, {2'b01, 4'h0, b, 1'b0, s});
    wait_idle();
    rd_chk(nm, `CPRAM_DATA_OFS, e);
  endtask : get

  // Output pulse is captured at the edge after the one that took the byte
  task automatic line(input logic [6:0] s, input logic [7:0] rb, input logic [7:0] tb,
                      input logic tv);
    lineIn <= '{rb, 1'b1, tb, tv, s};
    @(posedge sys_clk);
    lineIn.rxValid <= 1'b0;
    lineIn.txValid <= 1'b0;
    @(posedge sys_clk);
    got = rxOut;
  endtask : line

  initial begin
    n_fail = 0;
    compares = 0;
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0000_0000;
    rxUnchannelized = 1'b0;
    lineIn = '0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd_chk("sel reset", `CPRAM_SEL_OFS, `CPRAM_SEL_RESET);
    rd_chk("data reset", `CPRAM_DATA_OFS, `CPRAM_DATA_RESET);
    wbx(1'b1, 8'h08, 16'hffff);
    rd_chk("unmapped", 8'h08, 16'h0000);
    for (int b = 1; b < 3; b++) for (int s = 0; s < 128; s += 127)
      put(b[1:0], s[6:0], 16'ha500 + 16'(b * 256 + s));
    for (int b = 1; b < 3; b++) for (int s = 0; s < 128; s += 127)
      get("bank word", b[1:0], s[6:0], 16'ha500 + 16'(b * 256 + s));
    line(7'h7f, 8'h00, 8'h00, 1'b0);
    @(posedge sys_clk);
    chk("tx cfg", 32'h0000_a77f, {16'h0000, txCfgWord});
    wbx(1'b1, `CPRAM_SEL_OFS, 16'hc17f);
    wait_idle();
    rd_chk("busy ro", `CPRAM_SEL_OFS, 16'h417f);
    rd_chk("read dest", `CPRAM_DATA_OFS, 16'ha67f);
    get("bank 11", 2'b11, 7'h05, 16'h0000);
    put(2'b01, 7'h05, 16'hd0ff);
    line(7'h05, 8'h3c, 8'h96, 1'b1);
    chk("hdlc", {1'b1, 9'h100, 8'h3c}, {got.hdlcValid, got.hdlcChannel, got.hdlcByte});
    chk("search", {1'b1, 8'h3c}, {got.searchValid, got.searchByte});
    chk("tester", {1'b1, 1'b0, 8'h3c}, {got.testerValid, got.sevenBit, got.testerByte});
    get("byte store", 2'b00, 7'h05, 16'h963c);
    put(2'b01, 7'h05, 16'h91ff);
    line(7'h05, 8'h3c, 8'h00, 1'b0);
    chk("seven", 3'b110, {got.sevenBit, got.searchValid, got.testerValid});
    put(2'b01, 7'h05, 16'h9100);
    line(7'h05, 8'h3d, 8'h00, 1'b0);
    chk("search all", {1'b1, 8'h3d}, {got.searchValid, got.searchByte});
    put(2'b01, 7'h05, 16'h8400);
    line(7'h05, 8'h3c, 8'h00, 1'b0);
    chk("loop", {9'h001, 8'h96}, {got.hdlcChannel, got.hdlcByte});
    put(2'b01, 7'h05, 16'h8500);
    line(7'h05, 8'h3c, 8'h00, 1'b0);
    chk("loop off", {8'h3c}, {got.hdlcByte});
    // Entry 0 decides channel and enable for every slot in this mode
    put(2'b01, 7'h00, 16'h8010);
    put(2'b01, 7'h05, 16'h00ff);
    rxUnchannelized <= 1'b1;
    line(7'h05, 8'h3c, 8'h00, 1'b0);
    chk("unchan", {1'b1, 9'h011}, {got.hdlcValid, got.hdlcChannel});
    stop_test();
  end
endmodule : cpram_port_tb
